/* File: design/cth_tx_handler.sv */
// CAN transmit handler: APB registers, request scan and frame launch
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Classic frame unless FD enabled and flagged
// - FD without switch if either switch bit 0
// - Rate switch only when all four bits set
// - Rescan on pending change or transmit start
// - Lowest pending identifier wins the scan
// - Optional two idle bit pause after success
// - Pause enable resets to zero
// - Received frame ends the pause at once
// - Buffer sends with its configured identifier
// - Equal identifiers: lowest buffer index first
// - Buffers compete with FIFO by identifier
module cth_tx_handler (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   srst_in,
  // APB slave
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [cth_pkg::AW-1:0] paddr_in,
  input  wire logic [31:0]            pwdata_in,
  output logic                        pready_out,
  output logic [31:0]                 prdata_out,
  output logic                        pslverr_out,
  // Protocol controller events
  input  wire logic                   bit_tick_in,
  input  wire logic                   bus_idle_in,
  input  wire logic                   sof_in,
  input  wire logic                   tx_ok_in,
  input  wire logic                   tx_lost_in,
  input  wire logic                   rx_done_in,
  // Frame launch to the protocol controller
  output logic                        tx_start_out,
  output logic [cth_pkg::IDW-1:0]     tx_id_out,
  output logic                        tx_fd_out,
  output logic                        tx_brs_out,
  output logic [cth_pkg::IDXW-1:0]    tx_buf_out,
  output logic                        tx_fifo_out,
  // Transmit FIFO head
  input  wire logic                   fifo_req_in,
  input  wire logic [cth_pkg::IDW-1:0] fifo_id_in,
  input  wire logic                   fifo_fdf_in,
  input  wire logic                   fifo_brs_in,
  output logic                        fifo_sent_out
);
  import cth_pkg::*;

  typedef enum logic {ST_IDLE, ST_TX} cth_state_e;

  // Register state and next values
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [NBUF-1:0]   pend_r, pend_nxt, pend_q_r;
  logic [NBUF-1:0]   fdf_r, fdf_nxt, ebrs_r, ebrs_nxt;
  logic [IDW-1:0]    id_r [NBUF];
  logic [IDW-1:0]    id_nxt [NBUF];
  logic [IDXW-1:0]   sel_r, sel_nxt;
  logic              sel_ok_r, sel_ok_nxt;
  cth_state_e        st_r, st_nxt;
  logic              start_nxt, fd_nxt, brs_nxt, fifo_nxt, sent_nxt;
  logic [IDW-1:0]    txid_nxt;
  logic [IDXW-1:0]   buf_nxt;
  logic              rdy_r, rdy_nxt, err_r, err_nxt;
  logic [31:0]       rdata_r, rdata_nxt;

  // Decode and arbitration terms
  logic              acc, wr, hit, is_buf, trig, buf_rdy, use_fifo, go, fifo_ok;
  logic              pause_act, ok_evt;
  logic [IDXW-1:0]   bidx;
  logic [IDW-1:0]    sel_id;
  logic              sel_fdf, sel_ebrs;
  logic [NBUF-1:0]   clr, set;
  logic [31:0]       rd;

  cth_scan_if sc ();

  // Pending set and identifiers feed the scanner
  assign sc.pend = pend_r;
  assign sc.id   = id_r;

  cth_scan u_scan (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .sc      (sc.scan)
  );

  // Pause only follows own successful frames
  assign ok_evt = (st_r == ST_TX) && tx_ok_in;

  cth_pause u_pause (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .enable_in   (ctrl_r[CTRL_TXP_BIT]),
    .tx_ok_in    (ok_evt),
    .rx_done_in  (rx_done_in),
    .sof_in      (sof_in),
    .bit_tick_in (bit_tick_in),
    .bus_idle_in (bus_idle_in),
    .active_out  (pause_act)
  );

  // Format from controller enables and element flags, returns {brs, fd}
  function automatic logic [1:0] frame_fmt(input logic fd_operation_enable, input logic bit_rate_switch_enable,
                                           input logic fdf, input logic ebrs);
    logic fd;
    fd = fd_operation_enable & fdf;
    frame_fmt = {fd & bit_rate_switch_enable & ebrs, fd};
  endfunction

  // Selected buffer view and launch decision
  assign sel_id   = id_r[sel_r];
  assign sel_fdf  = fdf_r[sel_r];
  assign sel_ebrs = ebrs_r[sel_r];
  assign trig     = (pend_r != pend_q_r) || tx_start_out;
  // A stale choice is never launched while a rescan is due
  assign buf_rdy  = sel_ok_r && pend_r[sel_r] && !trig;
  // Head just popped is stale until the FIFO advances, else it goes twice
  assign fifo_ok  = fifo_req_in && !fifo_sent_out;
  assign use_fifo = fifo_ok && (!buf_rdy || fifo_id_in < sel_id);
  assign go       = (st_r == ST_IDLE) && bus_idle_in && !pause_act
                    && (buf_rdy || fifo_ok);

  // APB address decode and read mux
  assign acc    = psel_in && penable_in;
  assign is_buf = (paddr_in >= BUF0_OFF) && (paddr_in < BUF_END);
  assign bidx   = paddr_in[IDXW+1:2];
  always_comb
  begin
    rd  = 32'h0000_0000;
    hit = (paddr_in[1:0] == 2'h0);
    if (is_buf)
    begin
      rd[BUF_ID_LSB +: IDW] = id_r[bidx];
      rd[BUF_FDF_BIT]       = fdf_r[bidx];
      rd[BUF_EBRS_BIT]      = ebrs_r[bidx];
    end
    else if (paddr_in == CTRL_OFF)
      rd = 32'(ctrl_r);
    else if (paddr_in == PEND_OFF)
      rd = 32'(pend_r);
    else if (paddr_in == STAT_OFF)
    begin
      rd[STAT_BUSY_BIT]            = (st_r == ST_TX);
      rd[STAT_SELOK_BIT]           = sel_ok_r;
      rd[STAT_PAUSE_BIT]           = pause_act;
      rd[STAT_SEL_LSB +: IDXW]     = sel_r;
    end
    else if (paddr_in != ADD_OFF)
      hit = 1'b0;
  end

  // Writes land on the completing edge of the access phase
  assign wr = acc && rdy_r && pwrite_in && hit;

  // Pending bits: software adds, a successful buffer frame removes
  always_comb
  begin
    clr = '0;
    set = '0;
    if (ok_evt && !tx_fifo_out)
      clr[tx_buf_out] = 1'b1;
    if (wr && paddr_in == ADD_OFF)
      set = pwdata_in[NBUF-1:0];
  end
  // Set after clear, so a new request in the same cycle survives
  assign pend_nxt = (pend_r & ~clr) | set;

  // APB handshake: one wait state, read data captured in it
  always_comb
  begin
    rdy_nxt   = acc && !rdy_r;
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (acc && !rdy_r)
    begin
      rdata_nxt = rd;
      err_nxt   = !hit;
    end
  end

  // Configuration writes
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    fdf_nxt  = fdf_r;
    ebrs_nxt = ebrs_r;
    id_nxt   = id_r;
    if (wr && paddr_in == CTRL_OFF)
      ctrl_nxt = pwdata_in[CTRL_W-1:0];
    if (wr && is_buf)
    begin
      id_nxt[bidx]   = pwdata_in[BUF_ID_LSB +: IDW];
      fdf_nxt[bidx]  = pwdata_in[BUF_FDF_BIT];
      ebrs_nxt[bidx] = pwdata_in[BUF_EBRS_BIT];
    end
  end

  // Scan capture and launch sequencing
  always_comb
  begin
    sel_nxt    = sel_r;
    sel_ok_nxt = sel_ok_r;
    st_nxt     = st_r;
    start_nxt  = 1'b0;
    sent_nxt   = 1'b0;
    txid_nxt   = tx_id_out;
    fd_nxt     = tx_fd_out;
    brs_nxt    = tx_brs_out;
    buf_nxt    = tx_buf_out;
    fifo_nxt   = tx_fifo_out;
    if (trig)
    begin
      sel_nxt    = sc.idx;
      sel_ok_nxt = sc.hit;
    end
    case (st_r)
      ST_IDLE:
        if (go)
        begin
          st_nxt    = ST_TX;
          start_nxt = 1'b1;
          fifo_nxt  = use_fifo;
          if (use_fifo)
          begin
            txid_nxt          = fifo_id_in;
            {brs_nxt, fd_nxt} = frame_fmt(ctrl_r[CTRL_FD_OPERATION_ENABLE_BIT], ctrl_r[CTRL_BIT_RATE_SWITCH_ENABLE_BIT],
                                          fifo_fdf_in, fifo_brs_in);
          end
          else
          begin
            txid_nxt          = sel_id;
            buf_nxt           = sel_r;
            {brs_nxt, fd_nxt} = frame_fmt(ctrl_r[CTRL_FD_OPERATION_ENABLE_BIT], ctrl_r[CTRL_BIT_RATE_SWITCH_ENABLE_BIT],
                                          sel_fdf, sel_ebrs);
          end
        end
      ST_TX:
        if (tx_ok_in)
        begin
          st_nxt   = ST_IDLE;
          sent_nxt = tx_fifo_out;
        end
        else if (tx_lost_in)
          st_nxt = ST_IDLE; // Lost arbitration: request stays pending
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  // All state registers
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ctrl_r        <= CTRL_RST;
      pend_r        <= PEND_RST;
      pend_q_r      <= PEND_RST;
      fdf_r         <= '0;
      ebrs_r        <= '0;
      id_r          <= '{default: ID_RST};
      sel_r         <= '0;
      sel_ok_r      <= 1'b0;
      st_r          <= ST_IDLE;
      tx_start_out  <= 1'b0;
      tx_id_out     <= ID_RST;
      tx_fd_out     <= 1'b0;
      tx_brs_out    <= 1'b0;
      tx_buf_out    <= '0;
      tx_fifo_out   <= 1'b0;
      fifo_sent_out <= 1'b0;
      rdy_r         <= 1'b0;
      err_r         <= 1'b0;
      rdata_r       <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r        <= ctrl_nxt;
      pend_r        <= pend_nxt;
      pend_q_r      <= pend_r;
      fdf_r         <= fdf_nxt;
      ebrs_r        <= ebrs_nxt;
      id_r          <= id_nxt;
      sel_r         <= sel_nxt;
      sel_ok_r      <= sel_ok_nxt;
      st_r          <= st_nxt;
      tx_start_out  <= start_nxt;
      tx_id_out     <= txid_nxt;
      tx_fd_out     <= fd_nxt;
      tx_brs_out    <= brs_nxt;
      tx_buf_out    <= buf_nxt;
      tx_fifo_out   <= fifo_nxt;
      fifo_sent_out <= sent_nxt;
      rdy_r         <= rdy_nxt;
      err_r         <= err_nxt;
      rdata_r       <= rdata_nxt;
    end
  end

  // APB answers straight from registers
  assign pready_out  = rdy_r;
  assign prdata_out  = rdata_r;
  assign pslverr_out = rdy_r && err_r;

  // Checks
  a_fmt_classic: assert property (@(posedge clk_in) disable iff (srst_in)
    go && !use_fifo && !(ctrl_r[CTRL_FD_OPERATION_ENABLE_BIT] && sel_fdf)
    |=> tx_start_out && !tx_fd_out && !tx_brs_out)
    else $error("classic frame expected");
  a_fmt_fd_plain: assert property (@(posedge clk_in) disable iff (srst_in)
    go && !use_fifo && ctrl_r[CTRL_FD_OPERATION_ENABLE_BIT] && sel_fdf && !(ctrl_r[CTRL_BIT_RATE_SWITCH_ENABLE_BIT] && sel_ebrs)
    |=> tx_fd_out && !tx_brs_out)
    else $error("FD frame without rate switch expected");
  a_fmt_fd_brs: assert property (@(posedge clk_in) disable iff (srst_in)
    go && !use_fifo && ctrl_r[CTRL_FD_OPERATION_ENABLE_BIT] && ctrl_r[CTRL_BIT_RATE_SWITCH_ENABLE_BIT] && sel_fdf && sel_ebrs
    |=> tx_fd_out && tx_brs_out)
    else $error("FD frame with rate switch expected");
  a_scan_on_change: assert property (@(posedge clk_in) disable iff (srst_in)
    pend_r != pend_q_r |=> sel_ok_r == $past(sc.hit) && sel_r == $past(sc.idx))
    else $error("scan result not captured after pending change");
  a_pause_rst_zero: assert property (@(posedge clk_in)
    srst_in |=> !ctrl_r[CTRL_TXP_BIT])
    else $error("pause enable not cleared by reset");
  a_no_start_pause: assert property (@(posedge clk_in) disable iff (srst_in)
    pause_act |=> !tx_start_out)
    else $error("frame launched during pause");
  a_buf_id_used: assert property (@(posedge clk_in) disable iff (srst_in)
    go && !use_fifo |=> tx_id_out == $past(sel_id) && tx_buf_out == $past(sel_r))
    else $error("buffer frame launched with wrong identifier");
  a_fifo_by_id: assert property (@(posedge clk_in) disable iff (srst_in)
    go && buf_rdy && fifo_ok |=> tx_fifo_out == ($past(fifo_id_in) < $past(sel_id)))
    else $error("FIFO and buffer not ordered by identifier");
endmodule
`default_nettype wire

/* File: inc/cth_pkg.sv */
// Shared constants for the CAN transmit handler
package cth_pkg;
  // Buffer count and widths
  localparam int NBUF = 4;
  localparam int IDXW = 2;
  localparam int IDW  = 11;
  localparam int AW   = 8;
  localparam int CTRL_W = 3;
  localparam int PCW    = 2;
  // Register byte offsets
  localparam logic [AW-1:0] CTRL_OFF = 8'h00;
  localparam logic [AW-1:0] ADD_OFF  = 8'h04;
  localparam logic [AW-1:0] PEND_OFF = 8'h08;
  localparam logic [AW-1:0] STAT_OFF = 8'h0C;
  localparam logic [AW-1:0] BUF0_OFF = 8'h10;
  localparam logic [AW-1:0] BUF_END  = 8'h20;
  // Control register fields
  localparam int CTRL_FD_OPERATION_ENABLE_BIT = 0;
  localparam int CTRL_BIT_RATE_SWITCH_ENABLE_BIT = 1;
  localparam int CTRL_TXP_BIT  = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  // Buffer configuration fields
  localparam int BUF_ID_LSB   = 0;
  localparam int BUF_FDF_BIT  = 16;
  localparam int BUF_EBRS_BIT = 17;
  // Status register fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_SELOK_BIT = 1;
  localparam int STAT_PAUSE_BIT = 2;
  localparam int STAT_SEL_LSB   = 4;
  // Reset values
  localparam logic [NBUF-1:0] PEND_RST = 4'h0;
  localparam logic [IDW-1:0]  ID_RST   = 11'h000;
  // Pause length in nominal bit times
  localparam logic [PCW-1:0] PAUSE_BITS = 2'h2;
endpackage

/* File: inc/cth_scan_if.sv */
// Carrier between the handler and its priority scanner
`timescale 1ns/100ps
`default_nettype none
interface cth_scan_if;
  import cth_pkg::*;
  logic [NBUF-1:0] pend;
  logic [IDW-1:0]  id [NBUF];
  logic            hit;
  logic [IDXW-1:0] idx;
  modport ctl  (output pend, output id, input hit, input idx);
  modport scan (input pend, input id, output hit, output idx);
endinterface
`default_nettype wire

/* File: design/cth_scan.sv */
// Priority scanner: lowest identifier, then lowest buffer index
`timescale 1ns/100ps
`default_nettype none
module cth_scan (
  // Clock and reset, for checks only
  input  wire logic   clk_in,
  input  wire logic   srst_in,
  // Scan request and result
  cth_scan_if.scan    sc
);
  import cth_pkg::*;

  logic            hit_c;
  logic [IDXW-1:0] idx_c;
  logic [IDW-1:0]  best_c;

  // Ascending walk with strict compare keeps the lowest index on ties
  always_comb
  begin
    hit_c  = 1'b0;
    idx_c  = '0;
    best_c = '1;
    for (int i = 0; i < NBUF; i++)
    begin
      if (sc.pend[i] && (!hit_c || sc.id[i] < best_c))
      begin
        hit_c  = 1'b1;
        idx_c  = IDXW'(i);
        best_c = sc.id[i];
      end
    end
  end

  assign sc.hit = hit_c;
  assign sc.idx = idx_c;

  // Every other pending buffer loses against the winner
  for (genvar g = 0; g < NBUF; g++)
  begin : g_chk
    a_lowest_id_wins: assert property (@(posedge clk_in) disable iff (srst_in)
      sc.hit && sc.pend[g] |-> sc.id[g] >= sc.id[sc.idx])
      else $error("pending buffer with lower id not chosen");
    a_tie_low_index: assert property (@(posedge clk_in) disable iff (srst_in)
      sc.hit && sc.pend[g] && sc.id[g] == sc.id[sc.idx] |-> IDXW'(g) >= sc.idx)
      else $error("equal id tie not won by lowest index");
  end
endmodule
`default_nettype wire

/* File: design/cth_pause.sv */
// Transmit pause timer counted in nominal bit times
`timescale 1ns/100ps
`default_nettype none
module cth_pause (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic srst_in,
  // Control and bus events
  input  wire logic enable_in,
  input  wire logic tx_ok_in,
  input  wire logic rx_done_in,
  input  wire logic sof_in,
  input  wire logic bit_tick_in,
  input  wire logic bus_idle_in,
  // Pause state
  output logic      active_out
);
  import cth_pkg::*;

  logic [PCW-1:0] cnt_r;
  logic [PCW-1:0] cnt_nxt;

  // Load after own success, release early on foreign traffic
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (tx_ok_in && enable_in)
      cnt_nxt = PAUSE_BITS;
    else if (!enable_in || rx_done_in || sof_in)
      cnt_nxt = '0;
    else if (cnt_r != '0 && bit_tick_in && bus_idle_in)
      cnt_nxt = cnt_r - PCW'(1);
  end

  // Count register
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign active_out = (cnt_r != '0);

  sequence s_load;
    tx_ok_in && enable_in && !rx_done_in && !sof_in;
  endsequence

  sequence s_quiet2;
    (enable_in && !bit_tick_in && !rx_done_in && !sof_in)[*2];
  endsequence

  a_pause_holds: assert property (@(posedge clk_in) disable iff (srst_in)
    s_load ##1 s_quiet2 |-> active_out)
    else $error("pause ended before two bit times");
  a_pause_ends: assert property (@(posedge clk_in) disable iff (srst_in)
    cnt_r == PCW'(1) && bit_tick_in && bus_idle_in && !tx_ok_in |=> !active_out)
    else $error("pause outlasted two bit times");
  a_pause_abandon: assert property (@(posedge clk_in) disable iff (srst_in)
    (rx_done_in || sof_in) && !tx_ok_in |=> !active_out)
    else $error("pause kept after foreign frame");
endmodule
`default_nettype wire

/* File: sim/cth_bus_model.sv */
// Far-side model: protocol controller and other nodes around the handler
`timescale 1ns/100ps
`default_nettype none
module cth_bus_model #(
  parameter int FRAME = 12,
  parameter int TICK  = 16
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // Launch from the handler, commands from the bench
  input  wire logic       tx_start_in,
  input  wire logic       lose_in,
  input  wire logic       foreign_in,
  // Bus events toward the handler
  output logic            bit_tick_out,
  output logic            bus_idle_out,
  output logic            sof_out,
  output logic            tx_ok_out,
  output logic            tx_lost_out,
  output logic            rx_done_out,
  // Idle bit times since the last own success
  output logic [3:0]      ticks_out
);
  int   cnt_r;
  int   tick_r;
  logic own_r;

  // Quiet bus before the first reset edge
  initial
  begin
    {bit_tick_out, sof_out, tx_ok_out, tx_lost_out, rx_done_out, bus_idle_out} = 6'h01;
    ticks_out = 4'h0;
  end

  // One frame at a time; bit ticks only while the bus idles
  always @(posedge clk_in)
  begin
    bit_tick_out <= 1'b0;
    sof_out      <= 1'b0;
    tx_ok_out    <= 1'b0;
    tx_lost_out  <= 1'b0;
    rx_done_out  <= 1'b0;
    if (srst_in)
    begin
      cnt_r        <= 0;
      tick_r       <= 0;
      own_r        <= 1'b0;
      bus_idle_out <= 1'b1;
      ticks_out    <= 4'h0;
    end
    else if (tx_start_in)
    begin
      own_r        <= 1'b1;
      cnt_r        <= FRAME;
      bus_idle_out <= 1'b0;
    end
    else if (foreign_in && cnt_r == 0)
    begin
      // Another node takes the idle bus
      own_r        <= 1'b0;
      cnt_r        <= FRAME;
      sof_out      <= 1'b1;
      bus_idle_out <= 1'b0;
    end
    else if (cnt_r != 0)
    begin
      cnt_r <= cnt_r - 1;
      if (cnt_r == 1)
      begin
        // Frame end releases the bus; lost frames keep the tick count
        bus_idle_out <= 1'b1;
        tx_ok_out    <= own_r & ~lose_in;
        tx_lost_out  <= own_r & lose_in;
        rx_done_out  <= ~own_r;
        tick_r       <= 0;
        if (own_r && !lose_in)
          ticks_out <= 4'h0;
      end
    end
    else if (tick_r == TICK - 1)
    begin
      tick_r       <= 0;
      bit_tick_out <= 1'b1;
      if (ticks_out != 4'hF)
        ticks_out <= ticks_out + 4'h1;
    end
    else
      tick_r <= tick_r + 1;
  end
endmodule
`default_nettype wire

/* File: sim/cth_tx_handler_tb.sv */
// Self-checking bench for the CAN transmit handler
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module cth_tx_handler_tb;
  import cth_pkg::*;
  // Design pins
  logic              clk_in, srst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [AW-1:0]     paddr_in;
  logic [31:0]       pwdata_in, prdata_out, rd;
  logic              bit_tick_in, bus_idle_in, sof_in, tx_ok_in, tx_lost_in, rx_done_in;
  logic              tx_start_out, tx_fd_out, tx_brs_out, tx_fifo_out, fifo_sent_out;
  logic [IDW-1:0]    tx_id_out, fifo_id_in;
  logic [IDXW-1:0]   tx_buf_out;
  logic              fifo_req_in, fifo_fdf_in, fifo_brs_in;
  // Bench state
  logic              err, lose, foreign;
  logic [3:0]        ticks, seen_ticks;
  int                fails, n_compared;

  cth_tx_handler uut (.clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out,
    .prdata_out, .pslverr_out, .bit_tick_in, .bus_idle_in, .sof_in, .tx_ok_in, .tx_lost_in, .rx_done_in,
    .tx_start_out, .tx_id_out, .tx_fd_out, .tx_brs_out, .tx_buf_out, .tx_fifo_out, .fifo_req_in, .fifo_id_in,
    .fifo_fdf_in, .fifo_brs_in, .fifo_sent_out);

  cth_bus_model bus (.clk_in, .srst_in, .tx_start_in(tx_start_out), .lose_in(lose), .foreign_in(foreign),
    .bit_tick_out(bit_tick_in), .bus_idle_out(bus_idle_in), .sof_out(sof_in), .tx_ok_out(tx_ok_in),
    .tx_lost_out(tx_lost_in), .rx_done_out(rx_done_in), .ticks_out(ticks));

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  // Verdict and end of run
  task automatic complete_run();
    begin
      $display("Compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd);
    int n;
    begin
      @(posedge clk_in);
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= wr;
      paddr_in   <= a;
      pwdata_in  <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clk_in);
        n++;
      end
      while (pready_out !== 1'b1 && n < 50);
      `CHK(pready_out, 1'b1)
      rd  = prdata_out;
      err = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask

  task automatic apb_rd_chk(input logic [AW-1:0] a, input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      `CHK(rd, exp)
      `CHK(err, 1'b0)
    end
  endtask

  // Wait for a launch, or for the end of an own frame, sampled at the edge
  task automatic wait_for(input logic done_evt);
    int n;
    begin
      n = 0;
      do
      begin
        @(posedge clk_in);
        n++;
      end
      while ((done_evt ? (tx_ok_in | tx_lost_in) : tx_start_out) !== 1'b1 && n < 400);
      `CHK(n < 400, 1'b1)
    end
  endtask

  task automatic expect_launch(input logic [IDXW-1:0] b, input logic [IDW-1:0] id, input logic fifo);
    begin
      wait_for(1'b0);
      seen_ticks = ticks;
      `CHK(tx_id_out, id)
      `CHK(tx_fifo_out, fifo)
      if (!fifo)
        `CHK(tx_buf_out, b)
      wait_for(1'b1);
    end
  endtask

  // Another node sends one frame
  task automatic pulse_foreign();
    begin
      @(posedge clk_in);
      foreign <= 1'b1;
      @(posedge clk_in);
      foreign <= 1'b0;
    end
  endtask

  task automatic t_apb();
    begin
      apb_rd_chk(CTRL_OFF, 32'(CTRL_RST));
      apb_rd_chk(PEND_OFF, 32'(PEND_RST));
      apb(1'b0, 8'h40, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
      apb(1'b1, PEND_OFF, 32'hF);
      apb_rd_chk(PEND_OFF, 32'h0);
    end
  endtask

  // Every combination of the two enables and two element flags
  task automatic t_formats();
    logic [3:0] m;
    begin
      for (int i = 0; i < 16; i++)
      begin
        m = 4'(i);
        apb(1'b1, CTRL_OFF, {30'h0, m[3], m[2]});
        apb(1'b1, BUF0_OFF, {14'h0, m[0], m[1], 5'h0, 7'h12, m});
        apb(1'b1, ADD_OFF, 32'h1);
        expect_launch(2'h0, {7'h12, m}, 1'b0);
        `CHK(tx_fd_out, m[2] & m[1])
        `CHK(tx_brs_out, &m)
      end
    end
  endtask

  task automatic t_priority();
    logic [IDW-1:0] ids [NBUF];
    begin
      ids = '{11'h200, 11'h100, 11'h050, 11'h050};
      apb(1'b1, CTRL_OFF, 32'h0);
      for (int b = 0; b < NBUF; b++)
        apb(1'b1, BUF0_OFF + 8'(4 * b), 32'(ids[b]));
      apb(1'b1, ADD_OFF, 32'hF);
      expect_launch(2'h2, 11'h050, 1'b0);
      expect_launch(2'h3, 11'h050, 1'b0);
      expect_launch(2'h1, 11'h100, 1'b0);
      expect_launch(2'h0, 11'h200, 1'b0);
      apb_rd_chk(PEND_OFF, 32'h0);
    end
  endtask

  // New request during a losing frame must win the retry
  task automatic t_rescan();
    begin
      lose <= 1'b1;
      apb(1'b1, ADD_OFF, 32'h1);
      wait_for(1'b0);
      apb(1'b1, ADD_OFF, 32'h4);
      wait_for(1'b1);
      lose <= 1'b0;
      expect_launch(2'h2, 11'h050, 1'b0);
      expect_launch(2'h0, 11'h200, 1'b0);
    end
  endtask

  task automatic t_pause();
    begin
      apb(1'b1, CTRL_OFF, 32'h4);
      apb_rd_chk(CTRL_OFF, 32'h4);
      apb(1'b1, ADD_OFF, 32'h3);
      expect_launch(2'h1, 11'h100, 1'b0);
      expect_launch(2'h0, 11'h200, 1'b0);
      `CHK(seen_ticks, 4'(PAUSE_BITS))
      apb(1'b1, ADD_OFF, 32'h3);
      expect_launch(2'h1, 11'h100, 1'b0);
      pulse_foreign();
      expect_launch(2'h0, 11'h200, 1'b0);
      `CHK(seen_ticks, 4'h0)
      apb(1'b1, CTRL_OFF, 32'h0);
    end
  endtask

  // FIFO head competes with buffers while a foreign frame holds the bus
  task automatic t_fifo();
    begin
      fifo_id_in  <= 11'h050;
      fifo_fdf_in <= 1'b1;
      pulse_foreign();
      apb(1'b1, ADD_OFF, 32'h5);
      fifo_req_in <= 1'b1;
      expect_launch(2'h2, 11'h050, 1'b0);
      expect_launch(2'h0, 11'h050, 1'b1);
      `CHK(tx_fd_out, 1'b0)
      @(posedge clk_in);
      `CHK(fifo_sent_out, 1'b1)
      fifo_req_in <= 1'b0;
      expect_launch(2'h0, 11'h200, 1'b0);
    end
  endtask

  initial
  begin
    {clk_in, psel_in, penable_in, pwrite_in, fifo_req_in, fifo_fdf_in, fifo_brs_in, lose, foreign} = '0;
    {paddr_in, pwdata_in, fifo_id_in} = '0;
    {fails, n_compared} = '0;
    srst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    t_apb();
    t_formats();
    t_priority();
    t_rescan();
    t_pause();
    t_fifo();
    complete_run();
  end

  // Hang guard, well beyond the thousand or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_in);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
